// ---- bench/card_irq_tx_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// ********
// Pin checks of the card interrupt and transmit byte block.
// ********
module card_irq_tx_checker
    import card_irq_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic wait_timeout_in,
    input wire logic sync_mode_in,
    input wire logic rx_byte_in,
    input wire logic rx_fifo_full_in,
    input wire logic rx_parity_err_in,
    input wire logic card_irq_out,
    input wire logic [7:0] tx_byte_value_out,
    input wire logic tx_fifo_empty_out,
    input wire logic rx_overrun_out,
    input wire logic rx_parity_out
);
    logic [7:0] en_copy_reg;
    logic rd_tx, wr_tx, rd_rxc;

    // Enable copy; status bits are not at the pins.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            en_copy_reg <= 8'h00;
        end
        else if (bus_wr_in && bus_addr_in == ADDR_IRQ_ENABLE)
        begin
            en_copy_reg <= bus_wdata_in;
        end
    end

    // Decoded strobes.
    assign rd_tx = bus_rd_in && bus_addr_in == ADDR_TX_BYTE;
    assign wr_tx = bus_wr_in && bus_addr_in == ADDR_TX_BYTE;
    assign rd_rxc = bus_rd_in && bus_addr_in == ADDR_RX_CTRL;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Two back to back reads of the transmit byte.
    sequence two_tx_reads;
        rd_tx && !bus_wr_in ##1 rd_tx && !bus_wr_in;
    endsequence

    // A receive control read with no new receive error beside it.
    sequence quiet_rx_read;
        rd_rxc && !rx_byte_in && !rx_parity_err_in;
    endsequence

    AST_PUSH_SHOWS_HEAD: assert property (
        wr_tx && tx_fifo_empty_out && !bus_rd_in
        |=> !tx_fifo_empty_out && tx_byte_value_out == $past(bus_wdata_in))
        else $error("pushed byte not at head");
    AST_TWO_READS_EMPTY: assert property (two_tx_reads |=> tx_fifo_empty_out)
        else $error("two reads left fifo not empty");
    AST_READ_GIVES_HEAD: assert property (
        rd_tx && !tx_fifo_empty_out |=> bus_rdata_out == $past(tx_byte_value_out))
        else $error("read did not return head");
    AST_OVERRUN_SETS: assert property (
        rx_byte_in && rx_fifo_full_in |=> rx_overrun_out)
        else $error("overrun not flagged");
    AST_PARITY_SETS: assert property (rx_parity_err_in |=> rx_parity_out)
        else $error("parity error not flagged");
    AST_RX_CTRL_READ: assert property (
        quiet_rx_read |=> !rx_overrun_out && !rx_parity_out
        && bus_rdata_out == {6'h00, $past(rx_overrun_out), $past(rx_parity_out)})
        else $error("receive control read wrong");
    AST_MASKED_QUIET: assert property (
        $past(en_copy_reg) == 8'h00 && en_copy_reg == 8'h00 |-> !card_irq_out)
        else $error("interrupt with all causes masked");
    AST_WAIT_RAISES_IRQ: assert property (
        en_copy_reg[BIT_WAIT] && $past(en_copy_reg[BIT_WAIT]) && wait_timeout_in
        && !sync_mode_in |=> card_irq_out)
        else $error("enabled wait timeout gave no interrupt");
endmodule : card_irq_tx_checker

bind card_irq_tx card_irq_tx_checker chk (.*);

`default_nettype wire

// ---- bench/card_irq_tx_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module card_irq_tx_test
    import card_irq_pkg::*;
    ;
    logic clk, rst, wr, rd, sel, sync, byp, rxne, rxf, t1, t0, brk_en, rload;
    logic irq, txv, txe, txf, ovr, pty, clk_run, accept, io_fall, cclk, cio, pop, sent;
    logic [15:0] addr;
    logic [1:0] det;
    logic [7:0] wdata, rdata, ev, rmax, txb, last, v, en, b0, b1;
    logic [31:0] seed;
    logic [15:0] regs [4] = '{ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_TX_BYTE, 16'hfe05};
    logic [7:0] src_bit [3] = '{8'h80, 8'h20, 8'h04};
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    card_irq_tx dut (
        .ref_clk_in(clk), .sys_rst_in(rst), .card_clk_in(cclk),
        .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd), .bus_wdata_in(wdata),
        .bus_rdata_out(rdata), .interface_select_in(sel), .card_detect_pin_in(det),
        .wait_timeout_in(ev[0]), .supply_timer_done_in(ev[1]), .sync_mode_in(sync),
        .bypass_mode_in(byp), .rx_fifo_not_empty_in(rxne), .rx_byte_in(ev[5]),
        .rx_fifo_full_in(rxf), .rx_parity_err_in(ev[6]), .tx_byte_sent_in(sent | ev[7]),
        .tx_crc_sent_in(ev[2]), .t1_mode_in(t1), .t0_mode_in(t0), .break_enable_in(brk_en),
        .break_detected_in(ev[4]), .tx_underrun_in(ev[3]), .tx_pop_in(pop),
        .card_io_in(cio), .rlen_load_in(rload), .rlen_max_in(rmax), .card_irq_out(irq),
        .tx_byte_value_out(txb), .tx_valid_out(txv), .tx_fifo_empty_out(txe),
        .tx_fifo_full_out(txf), .rx_overrun_out(ovr), .rx_parity_out(pty)
    );

    card_side_model card (
        .ref_clk_in(clk), .sys_rst_in(rst), .clk_run_in(clk_run), .accept_in(accept),
        .io_fall_in(io_fall), .tx_valid_in(txv), .tx_byte_value_in(txb),
        .card_clk_out(cclk), .card_io_out(cio), .tx_pop_out(pop), .tx_sent_out(sent),
        .last_byte_out(last)
    );

    // ********
    // Clock, hang guard, helpers.
    // ********
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hang counts as a failure.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_fail++;
            complete_run();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic exp_irq(input logic [7:0] st, input logic [7:0] m);
        return |(st & m);
    endfunction : exp_irq

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    // Status read with one bit compared.
    task automatic st_bit(input int b, input logic e);
        bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk1(v[b], e);
    endtask : st_bit

    // One bus access; a read leaves its data in v.
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(negedge clk);
        v = rdata;
    endtask : bus

    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        repeat (2) @(negedge clk);
    endtask : pulse

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // ********
    // Main sequence.
    // ********
    initial
    begin
        rst = 1'b1;
        {wr, rd, sel, sync, byp, rxne, rxf, t1, t0, brk_en, rload} = 11'h000;
        {addr, wdata, det, ev, rmax, clk_run, accept, io_fall} = 45'h0;
        seed = 32'h24c1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], 8'h00);
            chk8(v, BYTE_RESET);
        end
        seed = lfsr(seed);
        bus(1'b1, ADDR_IRQ_ENABLE, seed[7:0]);
        bus(1'b0, ADDR_IRQ_ENABLE, 8'h00);
        chk8(v, seed[7:0]);
        $display("reset and enable test done");
        t1 <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            en = (k == 1) ? 8'h00 : src_bit[k];
            bus(1'b1, ADDR_IRQ_ENABLE, en);
            pulse(8'h01 << k);
            chk1(irq, exp_irq(src_bit[k], en));
            bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
            chk8(v, src_bit[k]);
            bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
            chk8(v, 8'h00);
            chk1(irq, 1'b0);
        end
        {t1, t0, brk_en} <= 3'b011;
        pulse(8'h98);
        st_bit(BIT_TXDONE, 1'b0);
        st_bit(BIT_TX_ERROR_FLAG, 1'b1);
        bus(1'b0, ADDR_TX_CTRL, 8'h00);
        st_bit(BIT_TX_ERROR_FLAG, 1'b0);
        $display("event test done");
        seed = lfsr(seed);
        {b0, b1} = seed[15:0];
        bus(1'b1, ADDR_TX_BYTE, b0);
        bus(1'b1, ADDR_TX_BYTE, b1);
        bus(1'b1, ADDR_TX_BYTE, ~b0);
        chk1(txf, 1'b1);
        bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
        st_bit(BIT_TXEV, 1'b1);
        bus(1'b0, ADDR_TX_CTRL, 8'h00);
        chk8(v, 8'h02);
        st_bit(BIT_TXEV, 1'b0);
        // Back to back reads.
        @(posedge clk);
        addr <= ADDR_TX_BYTE;
        rd <= 1'b1;
        repeat (2) @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk8(rdata, b1);
        chk1(txe, 1'b1);
        bus(1'b0, ADDR_TX_BYTE, 8'h00);
        chk8(v, b0);
        accept <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            bus(1'b1, ADDR_TX_BYTE, seed[7:0]);
            for (int n = 0; n < 20 && !txe; n++) @(negedge clk);
            chk8(last, seed[7:0]);
            st_bit(BIT_TXDONE, 1'b1);
        end
        accept <= 1'b0;
        $display("fifo test done");
        det[1] <= 1'b1;
        repeat (6) @(negedge clk);
        st_bit(BIT_CARD, 1'b0);
        det[0] <= 1'b1;
        repeat (6) @(negedge clk);
        st_bit(BIT_CARD, 1'b1);
        sel <= 1'b1;
        st_bit(BIT_CARD, 1'b1);
        sel <= 1'b0;
        rxne <= 1'b1;
        bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
        st_bit(BIT_RXAV, 1'b1);
        rxne <= 1'b0;
        st_bit(BIT_RXAV, 1'b0);
        rxf <= 1'b1;
        pulse(8'h60);
        st_bit(BIT_RX_ERROR_FLAG, 1'b1);
        bus(1'b0, ADDR_RX_CTRL, 8'h00);
        chk8(v, 8'h03);
        st_bit(BIT_RX_ERROR_FLAG, 1'b0);
        rxf <= 1'b0;
        $display("card event test done");
        {byp, clk_run} <= 2'b11;
        bus(1'b1, ADDR_IRQ_ENABLE, 8'h10);
        @(posedge clk) io_fall <= 1'b1;
        @(posedge clk) io_fall <= 1'b0;
        repeat (40) @(negedge clk);
        chk1(irq, 1'b1);
        bus(1'b1, ADDR_IRQ_ENABLE, 8'h00);
        byp <= 1'b0;
        sync <= 1'b1;
        @(posedge cclk);
        rmax <= 8'h03 + {6'h00, seed[1:0]};
        rload <= 1'b1;
        @(posedge cclk);
        rload <= 1'b0;
        repeat (60) @(negedge clk);
        st_bit(BIT_WAIT, 1'b1);
        $display("link test done");
        complete_run();
    end
endmodule : card_irq_tx_test

`default_nettype wire

// ---- bench/card_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ********
// Card side: card clock, I/O line and byte consumer.
// ********
module card_side_model (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_run_in,
    input wire logic accept_in,
    input wire logic io_fall_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_byte_value_in,
    output logic card_clk_out,
    output logic card_io_out,
    output logic tx_pop_out,
    output logic tx_sent_out,
    output logic [7:0] last_byte_out
);
    int wait_cnt;
    int io_cnt;
    logic slow;

    // Card clock: low between frames, phase offset.
    initial
    begin
        card_clk_out = 1'b0;
        #37;
        forever #80 card_clk_out = clk_run_in ? ~card_clk_out : 1'b0;
    end

    // I/O idles high by its pull-up; a start bit pulls it low.
    assign card_io_out = (io_cnt == 0);

    // Bytes are taken alternately at once and after a stall.
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            {wait_cnt, io_cnt} <= 64'h0;
            {slow, tx_pop_out, tx_sent_out, last_byte_out} <= 11'h000;
        end
        else
        begin
            {tx_pop_out, tx_sent_out} <= 2'b00;
            io_cnt <= io_fall_in ? 20 : (io_cnt > 0 ? io_cnt - 1 : 0);
            if (tx_valid_in && accept_in && !tx_pop_out)
            begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= (slow ? 6 : 0))
                begin
                    {tx_pop_out, tx_sent_out} <= 2'b11;
                    last_byte_out <= tx_byte_value_in;
                    slow <= ~slow;
                    wait_cnt <= 0;
                end
            end
        end
    end
endmodule : card_side_model

`default_nettype wire

// ---- src/card_irq_pkg.sv ----
package card_irq_pkg;

    // ****************************************************************
    // Register addresses on the processor data bus.
    // ****************************************************************
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hfe01;
    localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hfe02;
    localparam logic [15:0] ADDR_TX_CTRL = 16'hfe06;
    localparam logic [15:0] ADDR_TX_BYTE = 16'hfe07;
    localparam logic [15:0] ADDR_RX_CTRL = 16'hfe08;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int BIT_WAIT = 7;
    localparam int BIT_CARD = 6;
    localparam int BIT_SUPPLY = 5;
    localparam int BIT_RXAV = 4;
    localparam int BIT_TXEV = 3;
    localparam int BIT_TXDONE = 2;
    localparam int BIT_TX_ERROR_FLAG = 1;
    localparam int BIT_RX_ERROR_FLAG = 0;
    localparam int BIT_RX_OVERRUN = 1;
    localparam int BIT_RX_PARITY = 0;
    localparam int BIT_TXC_FULL = 1;
    localparam int BIT_TXC_EMPTY = 0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Status bits that a read of the status register clears.
    localparam logic [7:0] CLEAR_ON_READ_MASK = 8'he4;

    // ****************************************************************
    // Sizes.
    // ****************************************************************
    localparam int N_IF = 2;
    localparam int SEL_W = 1;
    localparam int TX_DEPTH = 2;
    localparam int TX_AW = 1;
    localparam int RLEN_W = 8;
    localparam logic [RLEN_W-1:0] RLEN_ZERO = 8'h00;
    localparam logic [RLEN_W-1:0] RLEN_ONE = 8'h01;
    localparam logic [TX_AW:0] PTR_ONE = 2'h1;
    localparam logic [TX_AW:0] PTR_ZERO = 2'h0;

endpackage : card_irq_pkg

// ---- src/card_irq_tx.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reading the status register clears wait, card event, supply and sent bits.
// - Status reads show only the interface picked by the select input.
// - A disabled cause still sets its status bit but raises no interrupt.
// - Each enable bit gates the status bit at the same position.
// - Bit 7 sets on wait timeout outside sync mode, or in sync mode on length counter maximum.
// - In sync mode bit 7 sets on the length counter terminal count, not on wait timeout.
// - Bit 6 sets on any change seen at the card detect pin.
// - Card event detection runs on the system clock, independent of card clock.
// - Bit 5 sets when the supply sequencing timer expires.
// - In normal mode bit 4 follows receive FIFO not empty and ignores status reads.
// - In bypass mode bit 4 sets on each falling edge of card I/O.
// - Bit 3 sets when TX empty or full rises; TX control read clears it.
// - Bit 2 sets per byte sent, and per check byte sent in T=1.
// - In T=0 with break detection, a break at byte end blocks bit 2.
// - Bit 1 sets on break or underrun; TX control read clears it.
// - Bit 0 sets on overrun or parity error; RX control read clears it.
// - Writing the TX byte register pushes into the FIFO for the sender.
// - Reading the TX byte register consumes one entry; two reads empty it.
// - Consuming FIFO entries never clears the storage cells.
// - Overrun flags when a byte arrives at full FIFO; RX control read clears it.
module card_irq_tx
    import card_irq_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic card_clk_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_wdata_in,
    output logic [7:0] bus_rdata_out,
    input wire logic [SEL_W-1:0] interface_select_in,
    input wire logic [N_IF-1:0] card_detect_pin_in,
    input wire logic wait_timeout_in,
    input wire logic supply_timer_done_in,
    input wire logic sync_mode_in,
    input wire logic bypass_mode_in,
    input wire logic rx_fifo_not_empty_in,
    input wire logic rx_byte_in,
    input wire logic rx_fifo_full_in,
    input wire logic rx_parity_err_in,
    input wire logic tx_byte_sent_in,
    input wire logic tx_crc_sent_in,
    input wire logic t1_mode_in,
    input wire logic t0_mode_in,
    input wire logic break_enable_in,
    input wire logic break_detected_in,
    input wire logic tx_underrun_in,
    input wire logic tx_pop_in,
    input wire logic card_io_in,
    input wire logic rlen_load_in,
    input wire logic [RLEN_W-1:0] rlen_max_in,
    output logic card_irq_out,
    output logic [7:0] tx_byte_value_out,
    output logic tx_valid_out,
    output logic tx_fifo_empty_out,
    output logic tx_fifo_full_out,
    output logic rx_overrun_out,
    output logic rx_parity_out
);

    // ****************************************************************
    // State types.
    // ****************************************************************
    typedef struct packed {
        logic io_s1;
        logic io_s2;
        logic io_s3;
        logic io_last;
        logic fall_tgl;
        logic [RLEN_W-1:0] rlen_cnt;
        logic [RLEN_W-1:0] rlen_max;
        logic rlen_tgl;
    } link_state_t;

    typedef struct packed {
        logic [N_IF-1:0] det_s1;
        logic [N_IF-1:0] det_s2;
        logic [N_IF-1:0] det_s3;
        logic [N_IF-1:0] det_level;
        logic [2:0] fall_sync;
        logic fall_seen;
        logic [2:0] rlen_sync;
        logic rlen_seen;
        logic [N_IF-1:0][7:0] status;
        logic [7:0] enable;
        logic [TX_DEPTH-1:0][7:0] tx_mem;
        logic [TX_AW:0] wr_ptr;
        logic [TX_AW:0] rd_ptr;
        logic tx_empty;
        logic tx_full;
        logic rx_overrun;
        logic rx_parity;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] tx_out;
        logic tx_valid;
    } sys_state_t;

    link_state_t link_reg;
    link_state_t link_next;
    sys_state_t sys_reg;
    sys_state_t sys_next;

    // Address decode shared by the read and write paths.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // ****************************************************************
    // Card clock domain: I/O fall detect and receive length counter.
    // ****************************************************************

    // Card I/O is async to the card clock: three flops, a fall counts once two agree.
    always_comb
    begin
        link_next = link_reg;
        link_next.io_s1 = card_io_in;
        link_next.io_s2 = link_reg.io_s1;
        link_next.io_s3 = link_reg.io_s2;
        if (link_reg.io_s2 == link_reg.io_s3)
        begin
            link_next.io_last = link_reg.io_s3;
            if (link_reg.io_last && !link_reg.io_s3)
            begin
                link_next.fall_tgl = !link_reg.fall_tgl;
            end
        end
        // Terminal count leaves as a toggle, since the card clock may stop right after.
        if (rlen_load_in)
        begin
            link_next.rlen_max = rlen_max_in;
            link_next.rlen_cnt = RLEN_ZERO;
        end
        else if (link_reg.rlen_cnt != link_reg.rlen_max)
        begin
            link_next.rlen_cnt = link_reg.rlen_cnt + RLEN_ONE;
            if ((link_reg.rlen_cnt + RLEN_ONE) == link_reg.rlen_max)
            begin
                link_next.rlen_tgl = !link_reg.rlen_tgl;
            end
        end
    end

    // Link domain register.
    always_ff @(posedge card_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            // Reset to the pulled-up idle level, so no false fall follows reset.
            link_reg <= '{io_s1: 1'b1, io_s2: 1'b1, io_s3: 1'b1, io_last: 1'b1, default: '0};
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    // ****************************************************************
    // System clock domain: status, enables, TX FIFO and bus.
    // ****************************************************************
    logic rd_status;
    logic rd_tx_byte;
    logic rd_tx_ctrl;
    logic rd_rx_ctrl;
    logic wr_enable;
    logic wr_tx_byte;
    logic fall_evt;
    logic rlen_evt;
    logic [N_IF-1:0] det_evt;
    logic [7:0] set_bits;
    logic [7:0] sel_status;
    logic [TX_AW:0] count;
    logic [TX_AW:0] consume;
    logic [TX_AW:0] want;
    logic [TX_AW:0] rd_after;
    logic [TX_AW:0] wr_after;
    logic next_empty;
    logic next_full;
    logic any_irq;

    // Bus strobes qualified by address.
    always_comb
    begin
        rd_status = bus_rd_in && hit(bus_addr_in, ADDR_IRQ_STATUS);
        rd_tx_byte = bus_rd_in && hit(bus_addr_in, ADDR_TX_BYTE);
        rd_tx_ctrl = bus_rd_in && hit(bus_addr_in, ADDR_TX_CTRL);
        rd_rx_ctrl = bus_rd_in && hit(bus_addr_in, ADDR_RX_CTRL);
        wr_enable = bus_wr_in && hit(bus_addr_in, ADDR_IRQ_ENABLE);
        wr_tx_byte = bus_wr_in && hit(bus_addr_in, ADDR_TX_BYTE);
    end

    // Toggle crossings from the card clock domain, and the card detect pins.
    always_comb
    begin
        fall_evt = (sys_reg.fall_sync[1] == sys_reg.fall_sync[2])
            && (sys_reg.fall_sync[2] != sys_reg.fall_seen);
        rlen_evt = (sys_reg.rlen_sync[1] == sys_reg.rlen_sync[2])
            && (sys_reg.rlen_sync[2] != sys_reg.rlen_seen);
        det_evt = (~(sys_reg.det_s2 ^ sys_reg.det_s3))
            & (sys_reg.det_s3 ^ sys_reg.det_level);
    end

    // TX FIFO bookkeeping; pops and reads consume at most what is held.
    always_comb
    begin
        count = sys_reg.wr_ptr - sys_reg.rd_ptr;
        want = PTR_ZERO;
        if (tx_pop_in)
        begin
            want = want + PTR_ONE;
        end
        if (rd_tx_byte)
        begin
            want = want + PTR_ONE;
        end
        consume = (want > count) ? count : want;
        rd_after = sys_reg.rd_ptr + consume;
        wr_after = sys_reg.wr_ptr;
        if (wr_tx_byte && !sys_reg.tx_full)
        begin
            wr_after = sys_reg.wr_ptr + PTR_ONE;
        end
        next_empty = (wr_after == rd_after);
        next_full = (wr_after[TX_AW-1:0] == rd_after[TX_AW-1:0])
            && (wr_after[TX_AW] != rd_after[TX_AW]);
    end

    // Status bit sources; errors are only reported, firmware recovers.
    always_comb
    begin
        set_bits = BYTE_RESET;
        set_bits[BIT_WAIT] = sync_mode_in ? rlen_evt : wait_timeout_in;
        set_bits[BIT_SUPPLY] = supply_timer_done_in;
        set_bits[BIT_RXAV] = bypass_mode_in ? fall_evt : rx_fifo_not_empty_in;
        set_bits[BIT_TXEV] = (next_empty && !sys_reg.tx_empty)
            || (next_full && !sys_reg.tx_full);
        set_bits[BIT_TXDONE] = (tx_byte_sent_in
            && !(t0_mode_in && break_enable_in && break_detected_in))
            || (t1_mode_in && tx_crc_sent_in);
        set_bits[BIT_TX_ERROR_FLAG] = break_detected_in || tx_underrun_in;
        set_bits[BIT_RX_ERROR_FLAG] = (rx_byte_in && rx_fifo_full_in) || rx_parity_err_in;
        sel_status = sys_reg.status[interface_select_in];
    end

    // Main next-state process.
    always_comb
    begin
        sys_next = sys_reg;
        any_irq = 1'b0;
        // Detect pins use the system clock, so card events work with the card clock gated.
        sys_next.det_s1 = card_detect_pin_in;
        sys_next.det_s2 = sys_reg.det_s1;
        sys_next.det_s3 = sys_reg.det_s2;
        sys_next.det_level = sys_reg.det_level ^ det_evt;
        sys_next.fall_sync = {sys_reg.fall_sync[1:0], link_reg.fall_tgl};
        sys_next.rlen_sync = {sys_reg.rlen_sync[1:0], link_reg.rlen_tgl};
        if (sys_reg.fall_sync[1] == sys_reg.fall_sync[2])
        begin
            sys_next.fall_seen = sys_reg.fall_sync[2];
        end
        if (sys_reg.rlen_sync[1] == sys_reg.rlen_sync[2])
        begin
            sys_next.rlen_seen = sys_reg.rlen_sync[2];
        end

        // Clear first, then set, so an event in a clearing cycle is kept.
        for (int i = 0; i < N_IF; i++)
        begin
            if (i == int'(interface_select_in))
            begin
                if (rd_status)
                begin
                    sys_next.status[i] = sys_reg.status[i] & ~CLEAR_ON_READ_MASK;
                end
                if (rd_tx_ctrl)
                begin
                    sys_next.status[i][BIT_TXEV] = 1'b0;
                    sys_next.status[i][BIT_TX_ERROR_FLAG] = 1'b0;
                end
                if (rd_rx_ctrl)
                begin
                    sys_next.status[i][BIT_RX_ERROR_FLAG] = 1'b0;
                end
                // Bit 4 is a level in normal mode and never read-cleared.
                if (!bypass_mode_in)
                begin
                    sys_next.status[i][BIT_RXAV] = rx_fifo_not_empty_in;
                end
                else if (rd_status)
                begin
                    sys_next.status[i][BIT_RXAV] = 1'b0;
                end
                // Status sets regardless of enable; enable gates only the line.
                sys_next.status[i] = sys_next.status[i] | set_bits;
            end
            if (det_evt[i])
            begin
                sys_next.status[i][BIT_CARD] = 1'b1;
            end
            any_irq = any_irq || ((sys_next.status[i] & sys_reg.enable) != BYTE_RESET);
        end
        sys_next.irq = any_irq;
        if (wr_enable)
        begin
            sys_next.enable = bus_wdata_in;
        end
        // Receive error flags; an RX control read clears both, a new error in that cycle wins.
        if (rd_rx_ctrl)
        begin
            sys_next.rx_overrun = 1'b0;
            sys_next.rx_parity = 1'b0;
        end
        if (rx_byte_in && rx_fifo_full_in)
        begin
            sys_next.rx_overrun = 1'b1;
        end
        if (rx_parity_err_in)
        begin
            sys_next.rx_parity = 1'b1;
        end

        // TX FIFO: cells are written only, never cleared.
        if (wr_tx_byte && !sys_reg.tx_full)
        begin
            sys_next.tx_mem[sys_reg.wr_ptr[TX_AW-1:0]] = bus_wdata_in;
        end
        sys_next.wr_ptr = wr_after;
        sys_next.rd_ptr = rd_after;
        sys_next.tx_empty = next_empty;
        sys_next.tx_full = next_full;
        sys_next.tx_out = sys_next.tx_mem[rd_after[TX_AW-1:0]];
        sys_next.tx_valid = !next_empty;

        // Read data, registered one cycle after the strobe.
        if (rd_status)
        begin
            sys_next.rdata = sel_status;
        end
        else if (bus_rd_in && hit(bus_addr_in, ADDR_IRQ_ENABLE))
        begin
            sys_next.rdata = sys_reg.enable;
        end
        else if (rd_tx_byte)
        begin
            sys_next.rdata = sys_reg.tx_mem[sys_reg.rd_ptr[TX_AW-1:0]];
        end
        else if (rd_tx_ctrl)
        begin
            sys_next.rdata = BYTE_RESET;
            sys_next.rdata[BIT_TXC_EMPTY] = sys_reg.tx_empty;
            sys_next.rdata[BIT_TXC_FULL] = sys_reg.tx_full;
        end
        else if (rd_rx_ctrl)
        begin
            sys_next.rdata = BYTE_RESET;
            sys_next.rdata[BIT_RX_OVERRUN] = sys_reg.rx_overrun;
            sys_next.rdata[BIT_RX_PARITY] = sys_reg.rx_parity;
        end
        else if (bus_rd_in)
        begin
            sys_next.rdata = BYTE_RESET;
        end
    end

    // System register; the FIFO resets empty.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sys_reg <= '0;
            sys_reg.tx_empty <= 1'b1;
        end
        else
        begin
            sys_reg <= sys_next;
        end
    end

    // Outputs, each straight from a flop.
    assign bus_rdata_out = sys_reg.rdata;
    assign card_irq_out = sys_reg.irq;
    assign tx_byte_value_out = sys_reg.tx_out;
    assign tx_valid_out = sys_reg.tx_valid;
    assign tx_fifo_empty_out = sys_reg.tx_empty;
    assign tx_fifo_full_out = sys_reg.tx_full;
    assign rx_overrun_out = sys_reg.rx_overrun;
    assign rx_parity_out = sys_reg.rx_parity;

endmodule : card_irq_tx

`default_nettype wire
